// ==== include/crs_pkg.sv ====
// Shared constants for the completer request stream framer.
// Assumes a single 100 MHz clock domain and an APB master for control.
package crs_pkg;

  // ---------------------------------------------------------------
  // Packet geometry
  // ---------------------------------------------------------------
  localparam int CRS_DWORD_W     = 32;
  localparam int CRS_DESC_DWORDS = 4;
  localparam int CRS_DESC_W      = 128;
  localparam int CRS_LEN_W       = 11;
  localparam int CRS_BEAT_W      = 11;
  localparam int CRS_POS_W       = 16;
  localparam int CRS_START_W     = 5;
  localparam int CRS_LANE_BYTES  = 4;

  // ---------------------------------------------------------------
  // Sideband bus field positions
  // ---------------------------------------------------------------
  localparam int CRS_USER_W      = 53;
  localparam int CRS_U_FIRST_DWORD_BYTE_MASK  = 0;
  localparam int CRS_U_LAST_DWORD_BYTE_MASK   = 4;
  localparam int CRS_U_BYTE_EN   = 8;
  localparam int CRS_BYTE_EN_W   = 32;
  localparam int CRS_U_SOP       = 40;
  localparam int CRS_U_DISCARD   = 41;
  localparam int CRS_U_ST_TAG    = 42;
  localparam int CRS_ST_TAG_W    = 8;
  localparam int CRS_U_ST_TYPE   = 50;
  localparam int CRS_ST_TYPE_W   = 2;
  localparam int CRS_U_TPH       = 52;

  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam int          CRS_ADDR_W      = 12;
  localparam logic [11:0] CRS_OFS_CTRL    = 12'h000;
  localparam logic [11:0] CRS_OFS_STATUS  = 12'h004;
  localparam logic [11:0] CRS_OFS_PKTCNT  = 12'h008;
  localparam int          CRS_CTRL_ALIGN  = 0;
  localparam logic        CRS_CTRL_RST    = 1'b0;
  localparam int          CRS_STAT_BUSY   = 0;
  localparam int          CRS_STAT_VALID  = 1;
  localparam int          CRS_PKTCNT_W    = 16;
  localparam logic [3:0]  CRS_BE_ALL      = 4'hf;

endpackage

// ==== rtl/crs_request_framer.sv ====
// Completer request framer: turns received requests into stream packets.
// Assumes header and payload beats come from the link receive buffer on
// clk_in, and that payload beats are supplied without gaps once a
// request has been accepted.
//
// Notes on behaviour
// - Stream width 64, 128 or 256; keep per Dword.
// - Each request: 128-bit descriptor, then optional payload.
// - Dword mode: first byte on lane (16+A%4)%w.
// - Address mode: payload new beat, lane A%w.
// - Address from request; messages use zero.
// - Valid stays high until final beat transferred.
// - Receiver may stall any beat with ready low.
// - Keep high from descriptor through last payload Dword.
// - Keep low only in a short final beat.
// - Last flag marks final beat of every packet.
// - First beat carries first/last Dword byte masks.
// - Start flag, sideband bit 40, on first beat.
// - Byte valids only for real payload bytes.
// - Byte valids contiguous except payloads up to two.
// - Zero-length write: one Dword, no byte valids.
// - Dword mode gap of zero to three bytes.
// - Hint steering tag and type on sideband.
// - Address mode keeps keep high across gap.
`timescale 1ns/100ps
module crs_request_framer #(
  parameter int DATA_W = 256
) (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         nrst_in,
  // APB slave
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [11:0]                  paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  output logic      [31:0]                  prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  // Request header from link receive side
  input  wire logic                         req_valid_in,
  input  wire logic [127:0]                 req_desc_in,
  input  wire logic [4:0]                   req_addr_in,
  input  wire logic                         req_is_msg_in,
  input  wire logic [10:0]                  req_dwords_in,
  input  wire logic                         req_zero_len_in,
  input  wire logic [3:0]                   first_dword_byte_mask_in,
  input  wire logic [3:0]                   last_dword_byte_mask_in,
  input  wire logic                         req_tph_in,
  input  wire logic [7:0]                   req_st_tag_in,
  input  wire logic [1:0]                   req_st_type_in,
  output logic                              req_ready_out,
  // Payload beats, Dwords packed from lane 0
  input  wire logic                         pld_valid_in,
  input  wire logic [DATA_W-1:0]            pld_data_in,
  output logic                              pld_ready_out,
  // Completer request stream
  output logic [DATA_W-1:0]                 completer_request_tdata_out,
  output logic [DATA_W/32-1:0]              completer_request_tkeep_out,
  output logic                              completer_request_tlast_out,
  output logic                              completer_request_tvalid_out,
  input  wire logic                         completer_request_tready_in,
  output logic [crs_pkg::CRS_USER_W-1:0]    request_sideband_bus_out
);

  // ---------------------------------------------------------------
  // Local geometry
  // ---------------------------------------------------------------
  localparam int NDW = DATA_W / crs_pkg::CRS_DWORD_W;
  localparam int SW  = $clog2(NDW);
  localparam int PW  = crs_pkg::CRS_START_W;
  localparam int LW  = crs_pkg::CRS_LEN_W;
  localparam int QW  = crs_pkg::CRS_POS_W;
  localparam int UW  = crs_pkg::CRS_USER_W;
  // First payload position in address mode: the beat after the descriptor
  localparam int DESC_END = (NDW > crs_pkg::CRS_DESC_DWORDS) ?
                            NDW : crs_pkg::CRS_DESC_DWORDS;
  localparam int DESC_LANES = (NDW >= crs_pkg::CRS_DESC_DWORDS) ?
                              crs_pkg::CRS_DESC_W / 8 : DATA_W / 8;

  typedef enum logic {
    CRS_IDLE = 1'b0,
    CRS_SEND = 1'b1
  } crs_state_type;

  typedef struct packed {
    crs_state_type                  state;
    logic                           align_mode;
    logic                           pkt_align;
    logic [crs_pkg::CRS_BEAT_W-1:0] beat;
    logic [LW-1:0]                  n_dw;
    logic [PW-1:0]                  pstart;
    logic                           zero_len;
    logic [3:0]                     first_mask;
    logic [3:0]                     last_mask;
    logic                           tph;
    logic [7:0]                     st_tag;
    logic [1:0]                     st_type;
    logic [crs_pkg::CRS_DESC_W-1:0] desc;
    logic [DATA_W-1:0]              hold;
    logic                           hdr_ready;
    logic                           mid_pkt;
    logic                           out_valid;
    logic [DATA_W-1:0]              out_data;
    logic [NDW-1:0]                 out_keep;
    logic                           out_last;
    logic [UW-1:0]                  out_user;
    logic [crs_pkg::CRS_PKTCNT_W-1:0] pkt_cnt;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
  } crs_regs_type;

  crs_regs_type r_reg;
  crs_regs_type r_next;

  // ---------------------------------------------------------------
  // Beat geometry for the beat now being built
  // ---------------------------------------------------------------
  logic [QW-1:0] base;
  logic [QW-1:0] total;
  logic [QW-1:0] pq;
  logic          last_beat;
  logic          need_in;
  logic          adv;
  logic          take_beat;

  // Positions count Dwords from descriptor Dword 0
  assign base  = QW'({r_reg.beat, {SW{1'b0}}});
  assign total = QW'(r_reg.pstart) + QW'(r_reg.n_dw);
  assign pq    = QW'({r_reg.pstart[PW-1:SW], {SW{1'b0}}});
  assign last_beat = (base + QW'(NDW)) >= total;
  // An input beat is due once the payload window reaches this beat
  assign need_in   = (base >= pq) && ((base - pq) < QW'(r_reg.n_dw));

  wire [DATA_W-1:0]             beat_data;
  wire [NDW-1:0]                beat_keep;
  wire [crs_pkg::CRS_BYTE_EN_W-1:0] beat_be;

  // ---------------------------------------------------------------
  // Per-Dword lane steering
  // ---------------------------------------------------------------
  for (genvar s = 0; s < NDW; s++) begin : g_lane
    wire [QW-1:0] pos     = base + QW'(s);
    wire [QW-1:0] jdw     = pos - QW'(r_reg.pstart);
    wire          is_desc = pos < QW'(crs_pkg::CRS_DESC_DWORDS);
    wire          is_pay  = (pos >= QW'(r_reg.pstart)) && (pos < total);
    // Lanes below the start slot take the tail of the previous beat
    wire [SW-1:0] idx     = SW'(s) - r_reg.pstart[SW-1:0];
    wire          use_cur = SW'(s) >= r_reg.pstart[SW-1:0];
    wire [31:0]   cur_dw  = pld_data_in[32*idx +: 32];
    wire [31:0]   old_dw  = r_reg.hold[32*idx +: 32];
    // Keep covers descriptor, null gap and payload alike
    assign beat_keep[s] = pos < total;
    assign beat_data[32*s +: 32] =
      is_desc ? r_reg.desc[32*pos[1:0] +: 32] :
      !is_pay ? 32'h0000_0000 :
      use_cur ? cur_dw : old_dw;
    // Masks only on payload lanes; middle Dwords fully valid
    assign beat_be[4*s +: 4] =
      (!is_pay || r_reg.zero_len) ? 4'h0 :
      (jdw == '0) ? r_reg.first_mask :
      (jdw == QW'(r_reg.n_dw - 1'b1)) ? r_reg.last_mask :
      crs_pkg::CRS_BE_ALL;
  end
  if (NDW * crs_pkg::CRS_LANE_BYTES < crs_pkg::CRS_BYTE_EN_W) begin : g_be_pad
    assign beat_be[crs_pkg::CRS_BYTE_EN_W-1:NDW*crs_pkg::CRS_LANE_BYTES] = '0;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // One process builds every next value; APB, header and stream share it
  always_comb begin
    logic [PW-1:0] slot;
    logic          addr_mode;
    slot      = '0;
    addr_mode = 1'b0;
    r_next    = r_reg;
    adv       = !r_reg.out_valid || completer_request_tready_in;
    take_beat = (r_reg.state == CRS_SEND) && adv &&
                (!need_in || pld_valid_in);
    // Ready only while a due beat can move; tied to the stream handshake
    pld_ready_out = (r_reg.state == CRS_SEND) && adv && need_in;

    // Consumed beat leaves; a stalled beat keeps every field
    if (r_reg.out_valid && completer_request_tready_in) begin
      r_next.out_valid = 1'b0;
      r_next.mid_pkt   = !r_reg.out_last;
    end

    // Load the next beat of the packet
    if (take_beat) begin
      r_next.out_valid = 1'b1;
      r_next.out_data  = beat_data;
      r_next.out_keep  = beat_keep;
      r_next.out_last  = last_beat;
      r_next.out_user  = '0;
      r_next.out_user[crs_pkg::CRS_U_BYTE_EN +: crs_pkg::CRS_BYTE_EN_W] =
        beat_be;
      if (r_reg.beat == '0) begin
        r_next.out_user[crs_pkg::CRS_U_FIRST_DWORD_BYTE_MASK +: 4] =
          r_reg.first_mask;
        r_next.out_user[crs_pkg::CRS_U_LAST_DWORD_BYTE_MASK +: 4]  = r_reg.last_mask;
        r_next.out_user[crs_pkg::CRS_U_SOP]           = 1'b1;
        r_next.out_user[crs_pkg::CRS_U_TPH]           = r_reg.tph;
        if (r_reg.tph) begin
          r_next.out_user[crs_pkg::CRS_U_ST_TAG +: crs_pkg::CRS_ST_TAG_W] =
            r_reg.st_tag;
          r_next.out_user[crs_pkg::CRS_U_ST_TYPE +: crs_pkg::CRS_ST_TYPE_W] =
            r_reg.st_type;
        end
      end
      if (need_in) begin
        r_next.hold = pld_data_in;
      end
      r_next.beat = r_reg.beat + 1'b1;
      if (last_beat) begin
        r_next.state     = CRS_IDLE;
        r_next.hdr_ready = 1'b1;
        r_next.pkt_cnt   = r_reg.pkt_cnt + 1'b1;
      end
    end

    // Header acceptance; mode is frozen per packet
    if ((r_reg.state == CRS_IDLE) && r_reg.hdr_ready && req_valid_in) begin
      addr_mode = r_reg.align_mode && (req_dwords_in != '0);
      // Messages align as if addressed at zero
      if (!req_is_msg_in) begin
        slot = PW'(req_addr_in[SW+1:2]);
      end
      r_next.state     = CRS_SEND;
      r_next.hdr_ready = 1'b0;
      r_next.pkt_align = addr_mode;
      r_next.beat      = '0;
      r_next.n_dw      = req_dwords_in;
      r_next.pstart    = addr_mode ? (PW'(DESC_END) + slot) :
                                     PW'(crs_pkg::CRS_DESC_DWORDS);
      r_next.zero_len  = req_zero_len_in;
      r_next.first_mask = first_dword_byte_mask_in;
      r_next.last_mask  = last_dword_byte_mask_in;
      r_next.tph       = req_tph_in;
      r_next.st_tag    = req_st_tag_in;
      r_next.st_type   = req_st_type_in;
      r_next.desc      = req_desc_in;
    end

    // APB: answer ready in the first access cycle, zero wait states
    r_next.pready = psel_in && !penable_in;
    if (psel_in && !penable_in) begin
      r_next.prdata  = '0;
      r_next.pslverr = 1'b0;
      case (paddr_in)
        crs_pkg::CRS_OFS_CTRL: begin
          r_next.prdata[crs_pkg::CRS_CTRL_ALIGN] = r_reg.align_mode;
        end
        crs_pkg::CRS_OFS_STATUS: begin
          r_next.prdata[crs_pkg::CRS_STAT_BUSY]  = r_reg.state == CRS_SEND;
          r_next.prdata[crs_pkg::CRS_STAT_VALID] = r_reg.out_valid;
        end
        crs_pkg::CRS_OFS_PKTCNT: begin
          r_next.prdata[crs_pkg::CRS_PKTCNT_W-1:0] = r_reg.pkt_cnt;
        end
        default: begin
          r_next.pslverr = 1'b1;
        end
      endcase
    end
    // Write lands only at the completing edge
    if (psel_in && penable_in && r_reg.pready && pwrite_in &&
        (paddr_in == crs_pkg::CRS_OFS_CTRL)) begin
      r_next.align_mode = pwdata_in[crs_pkg::CRS_CTRL_ALIGN];
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg            <= '0;
      r_reg.state      <= CRS_IDLE;
      r_reg.align_mode <= crs_pkg::CRS_CTRL_RST;
      r_reg.hdr_ready  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign completer_request_tdata_out  = r_reg.out_data;
  assign completer_request_tkeep_out  = r_reg.out_keep;
  assign completer_request_tlast_out  = r_reg.out_last;
  assign completer_request_tvalid_out = r_reg.out_valid;
  assign request_sideband_bus_out     = r_reg.out_user;
  assign req_ready_out                = r_reg.hdr_ready;
  assign prdata_out                   = r_reg.prdata;
  assign pready_out                   = r_reg.pready;
  assign pslverr_out                  = r_reg.pslverr;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  logic           starve;
  logic [NDW-1:0] be_ok;
  assign starve = need_in && !pld_valid_in && (r_reg.state == CRS_SEND);
  for (genvar s = 0; s < NDW; s++) begin : g_chk
    assign be_ok[s] = r_reg.out_keep[s] ||
      (r_reg.out_user[crs_pkg::CRS_U_BYTE_EN + 4*s +: 4] == 4'h0);
  end

  property p_stall_hold;
    r_reg.out_valid && !completer_request_tready_in |=>
      r_reg.out_valid && $stable(r_reg.out_data) &&
      $stable(r_reg.out_keep) && $stable(r_reg.out_last) &&
      $stable(r_reg.out_user);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("stalled beat changed");

  property p_valid_cont;
    r_reg.out_valid && completer_request_tready_in && !r_reg.out_last &&
      !starve |=> r_reg.out_valid;
  endproperty
  a_valid_cont: assert property (p_valid_cont)
    else $error("valid dropped inside packet");

  property p_sop_first;
    r_reg.out_valid && !r_reg.mid_pkt |-> r_reg.out_user[crs_pkg::CRS_U_SOP];
  endproperty
  a_sop_first: assert property (p_sop_first)
    else $error("first beat without start flag");

  property p_sop_only;
    r_reg.out_valid && r_reg.mid_pkt |->
      !r_reg.out_user[crs_pkg::CRS_U_SOP] &&
      (r_reg.out_user[crs_pkg::CRS_U_LAST_DWORD_BYTE_MASK+3:0] == 8'h00);
  endproperty
  a_sop_only: assert property (p_sop_only)
    else $error("first-beat sideband in later beat");

  property p_keep_full;
    r_reg.out_valid && !r_reg.out_last |-> &r_reg.out_keep;
  endproperty
  a_keep_full: assert property (p_keep_full)
    else $error("keep low in non-final beat");

  property p_keep_contig;
    r_reg.out_valid |-> r_reg.out_keep[0] &&
      ((r_reg.out_keep & (r_reg.out_keep + NDW'(1))) == '0);
  endproperty
  a_keep_contig: assert property (p_keep_contig)
    else $error("keep not contiguous");

  property p_be_in_keep;
    r_reg.out_valid |-> &be_ok;
  endproperty
  a_be_in_keep: assert property (p_be_in_keep)
    else $error("byte valid outside kept lanes");

  property p_desc_no_be;
    r_reg.out_valid && r_reg.out_user[crs_pkg::CRS_U_SOP] |->
      (r_reg.out_user[crs_pkg::CRS_U_BYTE_EN +: DESC_LANES] == '0);
  endproperty
  a_desc_no_be: assert property (p_desc_no_be)
    else $error("byte valid on descriptor lanes");

  property p_last_ends;
    r_reg.out_valid && r_reg.out_last && completer_request_tready_in |=>
      !r_reg.mid_pkt &&
      (!r_reg.out_valid || r_reg.out_user[crs_pkg::CRS_U_SOP]);
  endproperty
  a_last_ends: assert property (p_last_ends)
    else $error("packet did not end at last beat");

  property p_addr_gap;
    r_reg.out_valid && r_reg.out_user[crs_pkg::CRS_U_SOP] &&
      r_reg.pkt_align && (NDW > crs_pkg::CRS_DESC_DWORDS) |->
      r_reg.out_user[crs_pkg::CRS_U_BYTE_EN +: DATA_W/8] == '0;
  endproperty
  a_addr_gap: assert property (p_addr_gap)
    else $error("payload in descriptor beat, address mode");

  c_stall: cover property (r_reg.out_valid && !completer_request_tready_in
    && r_reg.mid_pkt);
  c_addr_pkt: cover property (r_reg.out_valid && r_reg.pkt_align &&
    r_reg.out_last && r_reg.mid_pkt);
  c_zero_len: cover property (r_reg.out_valid && r_reg.zero_len &&
    r_reg.out_last);
  c_tph: cover property (r_reg.out_valid &&
    r_reg.out_user[crs_pkg::CRS_U_TPH]);

endmodule

// ==== testbench/crs_sink_model.sv ====
// Sink model of the user completer logic on the request stream.
// Assumes it watches the framer's stream outputs on the same clock.
`timescale 1ns/100ps
module crs_sink_model #(
  parameter int DATA_W = 128
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  // Stream from the framer
  input  wire logic [DATA_W-1:0]      tdata_in,
  input  wire logic [DATA_W/32-1:0]   tkeep_in,
  input  wire logic                   tlast_in,
  input  wire logic                   tvalid_in,
  input  wire logic [52:0]            user_in,
  // Stall pattern and ready
  input  wire logic [1:0]             stall_in,
  output logic                        tready_out
);
  localparam int NDW = DATA_W / 32;
  logic [31:0]              dw [0:63];
  logic [52:0]              first_user;
  logic [NDW-1:0]           last_keep;
  logic [1:0]               cnt;
  logic                     held;
  logic                     in_pkt;
  logic [DATA_W+NDW+54:0]   hold_val;
  int                       beats, be_count, first_pos, pkts, err;

  // --------------------------------------------------------------
  // Ready pattern: low for stall_in cycles out of every four
  // --------------------------------------------------------------
  assign tready_out = (cnt >= stall_in);

  // --------------------------------------------------------------
  // Beat capture; blocking so the bench sees totals once settled
  // --------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 2'h0;
      held = 1'b0;
      in_pkt = 1'b0;
      pkts = 0;
      err = 0;
    end else begin
      // A stalled beat must come back with every field unchanged
      if (held && hold_val !== {tvalid_in, tlast_in, tkeep_in, user_in,
                                tdata_in}) err++;
      if (in_pkt && !tvalid_in) err++;
      held = tvalid_in && !tready_out;
      hold_val = {tvalid_in, tlast_in, tkeep_in, user_in, tdata_in};
      cnt <= cnt + 2'h1;
      if (tvalid_in && tready_out) begin
        if (user_in[40] == in_pkt) err++;
        if (user_in[40]) begin
          beats = 0;
          be_count = 0;
          first_pos = -1;
          first_user = user_in;
        end
        for (int k = 0; k < NDW; k++) dw[beats*NDW+k] = tdata_in[32*k +: 32];
        // First payload byte found from the byte valids alone
        for (int j = 0; j < DATA_W/8; j++) if (user_in[8+j]) begin
          be_count++;
          if (first_pos < 0) first_pos = beats*DATA_W/8 + j;
        end
        if (!tlast_in && !(&tkeep_in)) err++;
        if (((tkeep_in + 1'b1) & tkeep_in) != 0) err++;
        beats++;
        last_keep = tkeep_in;
        in_pkt = !tlast_in;
        if (tlast_in) pkts++;
      end
    end
  end
endmodule

// ==== testbench/pcie_completer_request_stream_bench.sv ====
// Self-checking bench for the request framer at 128-bit stream width.
// Assumes the sink model stands on the stream and APB sets the mode.
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("Error %s expected %0h seen %0h", n, e, g); err_count++; end end
module pcie_completer_request_stream_bench;
  localparam int DW = 128;
  logic clk_in = 0, nrst_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd;
  logic pready_out, pslverr_out, er, req_ready_out, pld_ready_out;
  logic req_valid_in = 0, req_is_msg_in = 0, req_zero_len_in = 0;
  logic req_tph_in = 0, pld_valid_in = 0;
  logic [127:0] req_desc_in = '0, desc;
  logic [4:0] req_addr_in = '0;
  logic [10:0] req_dwords_in = '0;
  logic [3:0] first_dword_byte_mask_in = '0, last_dword_byte_mask_in = '0;
  logic [3:0] fbe, lbe, completer_request_tkeep_out;
  logic [7:0] req_st_tag_in = '0;
  logic [1:0] req_st_type_in = '0, stall_in = '0;
  logic [DW-1:0] pld_data_in = '0, completer_request_tdata_out;
  logic completer_request_tlast_out, completer_request_tvalid_out;
  wire logic completer_request_tready_in;
  logic [52:0] request_sideband_bus_out;
  int err_count, tests_run, cycles, pb, pnb, pdw, ae, npk;
  // Rows: mode, address, message, dwords, zero length, stall
  int rows [10][6] = '{'{0,5,0,7,0,0}, '{0,3,0,1,0,3}, '{0,2,0,2,0,1},
    '{0,0,0,0,0,0}, '{1,13,0,9,0,2}, '{1,29,0,4,0,0}, '{1,13,1,3,0,1},
    '{0,4,0,1,1,0}, '{1,7,0,1,1,3}, '{1,0,0,0,0,0}};

  crs_request_framer #(.DATA_W(DW)) i_crs_request_framer (
    .clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .req_valid_in,
    .req_desc_in, .req_addr_in, .req_is_msg_in, .req_dwords_in,
    .req_zero_len_in, .first_dword_byte_mask_in, .last_dword_byte_mask_in,
    .req_tph_in, .req_st_tag_in, .req_st_type_in, .req_ready_out,
    .pld_valid_in, .pld_data_in, .pld_ready_out,
    .completer_request_tdata_out, .completer_request_tkeep_out,
    .completer_request_tlast_out, .completer_request_tvalid_out,
    .completer_request_tready_in, .request_sideband_bus_out);
  crs_sink_model #(.DATA_W(DW)) i_crs_sink_model (
    .clk_in, .nrst_in, .stall_in, .tready_out(completer_request_tready_in),
    .tdata_in(completer_request_tdata_out),
    .tkeep_in(completer_request_tkeep_out),
    .tlast_in(completer_request_tlast_out),
    .tvalid_in(completer_request_tvalid_out),
    .user_in(request_sideband_bus_out));

  // ----------------------------------------------------------------
  // Clock, gapless payload supply and hang guard
  // ----------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (pld_valid_in && pld_ready_out) pb++;
    pld_valid_in <= (pb < pnb);
    for (int k = 0; k < 4; k++)
      pld_data_in[32*k +: 32] <= 32'(32'hc000_0000 + pb*4 + k);
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // APB transfer: request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    // Idle edge first: a back-to-back call never drives psel twice at once
    @(posedge clk_in);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, wr, a, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask

  task automatic send(input int md, a, ms, n, zl, st);
    apb(1'b1, crs_pkg::CRS_OFS_CTRL, 32'(md));
    stall_in <= 2'(st);
    pb = 0;
    pnb = (n + 3) / 4;
    pdw = n;
    ae = ms ? 0 : a;
    fbe = zl ? 4'h0 : 4'(4'hf << (ae % 4));
    lbe = (n > 1) ? 4'h7 : 4'h0;
    desc = {96'hd3d2d1d0_c3c2c1c0_b3b2b1b0, 32'(a)};
    {req_valid_in, req_is_msg_in, req_zero_len_in, req_tph_in} <=
      {1'b1, 1'(ms), 1'(zl), 1'(a)};
    {req_addr_in, req_dwords_in, req_desc_in} <= {5'(a), 11'(n), desc};
    {first_dword_byte_mask_in, last_dword_byte_mask_in} <= {fbe, lbe};
    {req_st_tag_in, req_st_type_in} <= {8'(8'h5a + a), 2'(a)};
    do @(posedge clk_in); while (req_ready_out !== 1'b1);
    req_valid_in <= 1'b0;
  endtask

  task automatic check(input int md, a, n, zl);
    int p, nt;
    p = md ? 4 + (ae % 16) / 4 : 4;
    nt = n ? p + n : 4;
    while (i_crs_sink_model.pkts != npk) @(posedge clk_in);
    `CHK("beats", (nt + 3) / 4, i_crs_sink_model.beats)
    `CHK("last_keep", 4'((1 << ((nt-1)%4+1)) - 1), i_crs_sink_model.last_keep)
    `CHK("first_byte", (n && !zl) ? p*4 + ae%4 : -1, i_crs_sink_model.first_pos)
    `CHK("valids", (zl || !n) ? 0 : (n == 1) ? $countones(fbe) : $countones(fbe) + $countones(lbe) + 4*(n-2), i_crs_sink_model.be_count)
    `CHK("masks", {lbe, fbe}, i_crs_sink_model.first_user[7:0])
    if (a % 2) `CHK("hint", {1'b1, 2'(a), 8'(8'h5a + a)}, i_crs_sink_model.first_user[52:42])
    `CHK("desc", desc, {i_crs_sink_model.dw[3], i_crs_sink_model.dw[2], i_crs_sink_model.dw[1], i_crs_sink_model.dw[0]})
    for (int i = 0; i < n; i++) `CHK("payload", 32'(32'hc000_0000 + i), i_crs_sink_model.dw[p+i])
    `CHK("stream_rules", 0, i_crs_sink_model.err)
  endtask

  // ----------------------------------------------------------------
  // Main sequence: reset, registers, table, mid-packet reset
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    `CHK("ready_in_reset", 1'b1, req_ready_out)
    nrst_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, crs_pkg::CRS_OFS_CTRL, 32'h0);
    `CHK("ctrl_reset", 32'h0, rd)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped", 1'b1, er)
    foreach (rows[r]) begin
      send(rows[r][0], rows[r][1], rows[r][2], rows[r][3], rows[r][4], rows[r][5]);
      npk++;
      check(rows[r][0], rows[r][1], rows[r][3], rows[r][4]);
      $display("test %0d done", r);
    end
    apb(1'b0, crs_pkg::CRS_OFS_PKTCNT, 32'h0);
    `CHK("pkt_count", 32'(npk), rd)
    apb(1'b0, crs_pkg::CRS_OFS_STATUS, 32'h0);
    `CHK("status_idle", 32'h0, rd)
    send(1, 9, 0, 9, 0, 3);
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b0;
    pnb = 0;
    repeat (2) @(posedge clk_in);
    `CHK("valid_in_reset", 1'b0, completer_request_tvalid_out)
    nrst_in <= 1'b1;
    @(posedge clk_in);
    npk = 1;
    send(1, 13, 0, 9, 0, 2);
    check(1, 13, 9, 0);
    $display("test reset_mid_packet done");
    conclude();
  end
endmodule
